// >>> design/upo_override_regs.sv
`timescale 1ns/1ns
module upo_override_regs
  import upo_pkg::*;
#(
  parameter int NUM_PORTS = upo_pkg::UPO_NUM_PORTS
) (
  // Clock and resets
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic link_reset_n,
  input wire logic global_reset_n,
  // Configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // Internal PHY defaults, four bits per port
  input wire logic [4*upo_pkg::UPO_CODE_W-1:0] dflt_swing,
  input wire logic [4*upo_pkg::UPO_CODE_W-1:0] dflt_deemph,
  input wire logic [4*upo_pkg::UPO_CODE_W-1:0] dflt_eq_init,
  input wire logic [4*upo_pkg::UPO_CODE_W-1:0] dflt_eq_func,
  // Settings applied to the PHY, four bits per port
  output logic [4*upo_pkg::UPO_CODE_W-1:0] phy_swing,
  output logic [4*upo_pkg::UPO_CODE_W-1:0] phy_deemph,
  output logic [4*upo_pkg::UPO_CODE_W-1:0] phy_eq_init,
  output logic [4*upo_pkg::UPO_CODE_W-1:0] phy_eq_func
);
  import upo_pkg::*;

  // Only the two-port and four-port builds exist
  if (NUM_PORTS != 2 && NUM_PORTS != 4) begin : g_bad_num_ports
    $error("NUM_PORTS must be 2 or 4");
  end

  // Both codes of a port share one byte lane
  if (2 * UPO_CODE_W > UPO_PORT_STRIDE) begin : g_bad_lane
    $error("two codes must fit one byte lane");
  end

  // Width of one settings bus across all four ports
  localparam int SET_W = 4 * UPO_CODE_W;

  // Reset pin synchronisers, two flops each
  logic link_meta_ff;
  logic link_sync_n_ff;
  logic glob_meta_ff;
  logic glob_sync_n_ff;

  // Combined synchronous clear
  logic clr;

  // Register storage and next values
  logic [31:0] swing_de_ff;
  logic [31:0] nxt_swing_de;
  logic [31:0] eq_ff;
  logic [31:0] nxt_eq;
  logic [31:0] ov_en_ff;
  logic [31:0] nxt_ov_en;

  // Write decode
  logic [31:0] wmask;
  logic wr_swing_de;
  logic wr_eq;
  logic wr_ov_en;

  // Read path
  logic [31:0] cfg_rdata_ff;
  logic [31:0] nxt_rdata;
  logic cfg_rvalid_ff;

  // Applied settings: next value built per port, then one flop per bus
  wire logic [SET_W-1:0] nxt_phy_swing;
  wire logic [SET_W-1:0] nxt_phy_deemph;
  wire logic [SET_W-1:0] nxt_phy_eq_init;
  wire logic [SET_W-1:0] nxt_phy_eq_func;
  logic [SET_W-1:0] phy_swing_ff;
  logic [SET_W-1:0] phy_deemph_ff;
  logic [SET_W-1:0] phy_eq_init_ff;
  logic [SET_W-1:0] phy_eq_func_ff;

  // Link reset pin; only the second flop is read by logic
  always_ff @(posedge ref_clk) begin
    link_meta_ff <= link_reset_n;
    link_sync_n_ff <= link_meta_ff;
  end

  // Global reset pin; only the second flop is read by logic
  always_ff @(posedge ref_clk) begin
    glob_meta_ff <= global_reset_n;
    glob_sync_n_ff <= glob_meta_ff;
  end

  // three reset sources
  // Pin resets take effect two to three edges late, through the synchronisers
  assign clr = rst | ~link_sync_n_ff | ~glob_sync_n_ff;

  // Byte enables widened to a bit mask
  assign wmask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};

  // One strobe per mapped offset; other offsets write nothing
  assign wr_swing_de = cfg_wr & (cfg_addr == UPO_OFS_SWING_DE);
  assign wr_eq = cfg_wr & (cfg_addr == UPO_OFS_EQ);
  assign wr_ov_en = cfg_wr & (cfg_addr == UPO_OFS_OV_EN);

  // Byte-masked merge of new data into each register
  always_comb begin
    nxt_swing_de = (swing_de_ff & ~wmask) | (cfg_wdata & wmask);
    nxt_eq = (eq_ff & ~wmask) | (cfg_wdata & wmask);
    nxt_ov_en = (ov_en_ff & ~(wmask & UPO_OV_EN_MASK)) |
                (cfg_wdata & wmask & UPO_OV_EN_MASK);
  end

  // swing and de-emphasis storage
  // Clear wins over a write, so writes during a clear are lost
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      swing_de_ff <= UPO_RST_SWING_DE;
    end else if (wr_swing_de) begin
      swing_de_ff <= nxt_swing_de;
    end
  end

  // equalizer code storage
  // Same clear priority as the swing register
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      eq_ff <= UPO_RST_EQ;
    end else if (wr_eq) begin
      eq_ff <= nxt_eq;
    end
  end

  // enable storage
  // Clearing the enables hands every setting back to its default
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      ov_en_ff <= UPO_RST_OV_EN;
    end else if (wr_ov_en) begin
      ov_en_ff <= nxt_ov_en;
    end
  end

  // Read select; unmapped offsets read as zero
  always_comb begin
    unique case (cfg_addr)
      UPO_OFS_SWING_DE: nxt_rdata = swing_de_ff;
      UPO_OFS_EQ: nxt_rdata = eq_ff;
      UPO_OFS_OV_EN: nxt_rdata = ov_en_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Read data follows the address every cycle; the strobe only marks it valid
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_rdata_ff <= 32'h0000_0000;
    end else begin
      cfg_rdata_ff <= nxt_rdata;
    end
  end

  // One-cycle valid pulse, one edge after the read strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_rvalid_ff <= 1'h0;
    end else begin
      cfg_rvalid_ff <= cfg_rd;
    end
  end

  // Per-port override selection
  for (genvar p = 0; p < 4; p++) begin : g_port
    localparam int B = p * UPO_PORT_STRIDE;
    localparam int O = p * UPO_CODE_W;
    // absent ports follow defaults
    // Their codes stay writable and readable; they just never reach the PHY
    localparam logic PRESENT = (p < NUM_PORTS);
    logic de_on;
    logic sw_on;
    logic eq_on;
    logic [UPO_CODE_W-1:0] swing_code;
    logic [UPO_CODE_W-1:0] deemph_code;
    logic [UPO_CODE_W-1:0] eq_init_code;
    logic [UPO_CODE_W-1:0] eq_func_code;

    assign de_on = PRESENT & ov_en_ff[B + UPO_DE_EN_POS];
    assign sw_on = PRESENT & ov_en_ff[B + UPO_SWING_EN_POS];
    assign eq_on = PRESENT & ov_en_ff[B + UPO_EQ_EN_POS];

    assign swing_code = swing_de_ff[B + UPO_HI_CODE_POS +: UPO_CODE_W];
    assign deemph_code = swing_de_ff[B + UPO_LO_CODE_POS +: UPO_CODE_W];
    assign eq_init_code = eq_ff[B + UPO_HI_CODE_POS +: UPO_CODE_W];
    assign eq_func_code = eq_ff[B + UPO_LO_CODE_POS +: UPO_CODE_W];

    // override or default
    // One equalization enable steers both the init and the functional code
    assign nxt_phy_swing[O +: UPO_CODE_W] = sw_on ? swing_code
                                                  : dflt_swing[O +: UPO_CODE_W];
    assign nxt_phy_deemph[O +: UPO_CODE_W] = de_on ? deemph_code
                                                   : dflt_deemph[O +: UPO_CODE_W];
    assign nxt_phy_eq_init[O +: UPO_CODE_W] = eq_on ? eq_init_code
                                                    : dflt_eq_init[O +: UPO_CODE_W];
    assign nxt_phy_eq_func[O +: UPO_CODE_W] = eq_on ? eq_func_code
                                                    : dflt_eq_func[O +: UPO_CODE_W];
  end

  // Applied swing; defaults keep flowing during a pin reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phy_swing_ff <= 16'h0000;
    end else begin
      phy_swing_ff <= nxt_phy_swing;
    end
  end

  // Applied de-emphasis
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phy_deemph_ff <= 16'h0000;
    end else begin
      phy_deemph_ff <= nxt_phy_deemph;
    end
  end

  // Applied equalizer init setting
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phy_eq_init_ff <= 16'h0000;
    end else begin
      phy_eq_init_ff <= nxt_phy_eq_init;
    end
  end

  // Applied equalizer functional setting
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phy_eq_func_ff <= 16'h0000;
    end else begin
      phy_eq_func_ff <= nxt_phy_eq_func;
    end
  end

  // Outputs come straight from their flops
  assign cfg_rdata = cfg_rdata_ff;
  assign cfg_rvalid = cfg_rvalid_ff;
  assign phy_swing = phy_swing_ff;
  assign phy_deemph = phy_deemph_ff;
  assign phy_eq_init = phy_eq_init_ff;
  assign phy_eq_func = phy_eq_func_ff;

endmodule

// >>> design/upo_pkg.sv
package upo_pkg;
  // Configuration offsets of the three registers
  localparam logic [7:0] UPO_OFS_SWING_DE = 8'he4;
  localparam logic [7:0] UPO_OFS_EQ = 8'he8;
  localparam logic [7:0] UPO_OFS_OV_EN = 8'hec;
  // Reset values
  localparam logic [31:0] UPO_RST_SWING_DE = 32'h0000_0000;
  localparam logic [31:0] UPO_RST_EQ = 32'h0000_0000;
  localparam logic [31:0] UPO_RST_OV_EN = 32'h0000_0000;
  // Field layout: each port owns one byte lane
  localparam int UPO_PORT_STRIDE = 8;
  localparam int UPO_HI_CODE_POS = 4;
  localparam int UPO_LO_CODE_POS = 0;
  localparam int UPO_DE_EN_POS = 0;
  localparam int UPO_SWING_EN_POS = 1;
  localparam int UPO_EQ_EN_POS = 2;
  // Writable bits of the enable register
  localparam logic [31:0] UPO_OV_EN_MASK = 32'h0707_0707;
  localparam int UPO_NUM_PORTS = 4;
  localparam int UPO_CODE_W = 4;
endpackage

// >>> sim/upo_phy_model.sv
`timescale 1ns/1ns
// PHY stand-in: distinct defaults per field so a crossed path shows up
module upo_phy_model (
  // Defaults offered to the block
  output logic [15:0] dflt_swing, dflt_deemph, dflt_eq_init, dflt_eq_func,
  // Applied codes, only observed
  input wire logic [15:0] phy_swing, phy_deemph, phy_eq_init, phy_eq_func
);
  assign {dflt_swing, dflt_deemph, dflt_eq_init, dflt_eq_func} = 64'haaaa_bbbb_cccc_dddd;
endmodule

// >>> sim/upo_override_regs_assertions.sv
`timescale 1ns/1ns
module upo_override_regs_chk (
  // Clock and resets
  input wire logic ref_clk, rst, link_reset_n, global_reset_n,
  // Configuration access
  input wire logic cfg_wr, cfg_rd, cfg_rvalid,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata, cfg_rdata,
  // Port swing path
  input wire logic [15:0] dflt_swing, phy_swing
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Clear held, then an enable read
  sequence clr(s); !s[*4] ##1 cfg_rd && cfg_addr == 8'hec; endsequence
  // Resets idle long enough that no clear can eat the write
  sequence wr4; (link_reset_n && global_reset_n)[*6] ##0 cfg_wr && cfg_addr == 8'he4
    && cfg_be == 4'hf; endsequence
  chk_rd_valid: assert property (cfg_rd |=> cfg_rvalid) else $error("no rvalid");
  chk_valid_rd: assert property (!cfg_rd |=> !cfg_rvalid) else $error("stray rvalid");
  chk_unmapped_zero: assert property (cfg_rd && !(cfg_addr inside {8'he4, 8'he8, 8'hec})
    |=> cfg_rdata == 32'h0) else $error("unmapped read");
  chk_rsvd_zero: assert property (cfg_rd && cfg_addr == 8'hec
    |=> (cfg_rdata & 32'hf8f8_f8f8) == 32'h0) else $error("reserved set");
  chk_wr_rd_back: assert property (wr4 ##1 !cfg_wr ##1 cfg_rd && cfg_addr == 8'he4
    |=> cfg_rdata == $past(cfg_wdata, 3)) else $error("readback");
  chk_dflt_reset: assert property ($fell(rst) |=> phy_swing == $past(dflt_swing))
    else $error("default lost");
  chk_link_clear: assert property (clr(link_reset_n) |=> cfg_rdata == 32'h0)
    else $error("link clear");
  chk_glob_clear: assert property (clr(global_reset_n) |=> cfg_rdata == 32'h0)
    else $error("global clear");
endmodule
bind upo_override_regs upo_override_regs_chk chk (.*);

// >>> sim/upo_override_regs_tb_top.sv
`timescale 1ns/1ns
module upo_override_regs_tb_top;
  logic ref_clk = 0, rst = 1, link_reset_n = 1, global_reset_n = 1, cfg_wr = 0, cfg_rd = 0;
  logic cfg_rvalid;
  logic [7:0] cfg_addr = 8'h0;
  logic [3:0] cfg_be = 4'hf;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
  logic [15:0] dflt_swing, dflt_deemph, dflt_eq_init, dflt_eq_func;
  logic [15:0] phy_swing, phy_deemph, phy_eq_init, phy_eq_func;
  // Outputs of the two-port build
  logic two_rvalid;
  logic [31:0] two_rdata;
  logic [15:0] two_swing, two_deemph, two_eq_init, two_eq_func;
  int num_errors = 0, tests_run = 0;
  upo_override_regs dut (.*);
  // Two-port build on the same inputs; ports 3 and 4 must stay on defaults
  upo_override_regs #(.NUM_PORTS(2)) dut_two (
    .ref_clk(ref_clk), .rst(rst), .link_reset_n(link_reset_n),
    .global_reset_n(global_reset_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(two_rdata), .cfg_rvalid(two_rvalid), .dflt_swing(dflt_swing),
    .dflt_deemph(dflt_deemph), .dflt_eq_init(dflt_eq_init), .dflt_eq_func(dflt_eq_func),
    .phy_swing(two_swing), .phy_deemph(two_deemph), .phy_eq_init(two_eq_init),
    .phy_eq_func(two_eq_func));
  upo_phy_model phy (.*);
  // 100 MHz clock
  initial forever #5 ref_clk = ~ref_clk;
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Idle edge after a write, so no strobe is driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b = 4'hf);
    {cfg_wr, cfg_addr, cfg_wdata, cfg_be} <= {1'h1, a, d, b};
    @(posedge ref_clk);
    cfg_wr <= 1'h0;
    @(posedge ref_clk);
  endtask
  // Answer comes one edge after the strobe; sampled mid-cycle, where it has settled
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    {cfg_rd, cfg_addr} <= {1'h1, a};
    @(posedge ref_clk);
    cfg_rd <= 1'h0;
    @(negedge ref_clk);
    check({30'h0, cfg_rvalid, two_rvalid}, 32'h3);
    check(cfg_rdata, e);
    check(two_rdata, e);
    @(posedge ref_clk);
  endtask
  task automatic sc_reset();
    rd(8'he4, 32'h0);
    rd(8'he8, 32'h0);
    rd(8'hec, 32'h0);
    rd(8'he0, 32'h0);
  endtask
  // Codes stored but ignored until enables are set, one enable per kind
  task automatic sc_override();
    wr(8'he8, 32'hfedc_ba98);
    wr(8'he4, 32'h7654_3210);
    rd(8'he4, 32'h7654_3210);
    check({phy_swing, phy_deemph}, 32'haaaa_bbbb);
    wr(8'hec, 32'h0402_0001);
    rd(8'hec, 32'h0402_0001);
    check({phy_swing, phy_deemph}, 32'ha5aa_bbb0);
    check({phy_eq_init, phy_eq_func}, 32'hfccc_eddd);
    check({two_swing, two_deemph}, 32'haaaa_bbb0);
    check({two_eq_init, two_eq_func}, 32'hcccc_dddd);
    wr(8'hec, 32'hffff_ffff);
    rd(8'hec, 32'h0707_0707);
    check({phy_swing, phy_deemph}, 32'h7531_6420);
    check({phy_eq_init, phy_eq_func}, 32'hfdb9_eca8);
    check({two_swing, two_deemph}, 32'haa31_bb20);
    check({two_eq_init, two_eq_func}, 32'hccb9_dda8);
  endtask
  // Byte enables pick lanes; a write with none set changes nothing
  task automatic sc_bytes();
    wr(8'he4, 32'hffff_ab00, 4'h2);
    rd(8'he4, 32'h7654_ab10);
    check({phy_swing, phy_deemph}, 32'h75a1_64b0);
    wr(8'hec, 32'h0000_0000, 4'h0);
    rd(8'hec, 32'h0707_0707);
  endtask
  // Either reset pin wipes codes and enables; writes during the clear are lost
  task automatic sc_clear(input bit g);
    wr(8'he4, 32'h1357_9bdf);
    wr(8'hec, 32'hffff_ffff);
    if (g) global_reset_n <= 1'h0;
    else link_reset_n <= 1'h0;
    repeat (5) @(posedge ref_clk);
    wr(8'he8, 32'h1234_5678);
    rd(8'hec, 32'h0);
    {link_reset_n, global_reset_n} <= 2'h3;
    repeat (4) @(posedge ref_clk);
    rd(8'he4, 32'h0);
    rd(8'he8, 32'h0);
    check({phy_eq_init, phy_eq_func}, 32'hcccc_dddd);
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    sc_reset();
    sc_override();
    sc_bytes();
    sc_clear(0);
    sc_clear(1);
    give_verdict();
  end
endmodule
